/* File: count_unit.sv */
/*
 * One 16-bit timer/event counter unit with optional capture, reload, down count and
 * output toggle. Assumes the machine-cycle tick comes from the owner and the pin is synchronous.
 */
`timescale 1ns/1ps
module count_unit #(
   parameter int WIDTH = timer_pkg::COUNT_WIDTH
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             machine_tick,
   input  wire logic             run,
   input  wire logic             counter_mode,
   input  wire logic             count_input,
   input  wire logic             count_down,
   input  wire logic             reload_enable,
   input  wire logic [WIDTH-1:0] reload_value,
   input  wire logic             capture_strobe,
   input  wire logic             overflow_clear,
   output logic      [WIDTH-1:0] count_value,
   output logic      [WIDTH-1:0] capture_value,
   output logic                  overflow_flag,
   output logic                  toggle_out
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] capture;
      logic             sample;
      logic             overflow;
      logic             toggle;
   } unit_state_t;

   unit_state_t s_q;
   unit_state_t s_d;
   logic        fall_seen;
   logic        step;
   logic        wrap;

   // A fall is a high sample followed by a low sample one machine cycle later.
   assign fall_seen = machine_tick && s_q.sample && !count_input;
   assign step      = run && (counter_mode ? fall_seen : machine_tick);
   assign wrap      = step && (count_down ? (s_q.count == '0) : (s_q.count == '1));

   always_comb begin
      s_d = s_q;
      if (machine_tick) begin
         s_d.sample = count_input;
      end
      if (step) begin
         // The new value shows in the cycle after the fall is detected.
         s_d.count = count_down ? s_q.count - 1'b1 : s_q.count + 1'b1;
         if (wrap) begin
            s_d.toggle = !s_q.toggle;
            if (reload_enable) begin
               s_d.count = reload_value;
            end
         end
      end
      if (capture_strobe) begin
         s_d.capture = s_q.count;
      end
      // Set wins over clear so an overflow in the clearing cycle is not lost.
      if (overflow_clear) begin
         s_d.overflow = 1'b0;
      end
      if (wrap) begin
         s_d.overflow = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_value   = s_q.count;
   assign capture_value = s_q.capture;
   assign overflow_flag = s_q.overflow;
   assign toggle_out    = s_q.toggle;

   property p_step_visible;
      @(posedge core_clk) disable iff (reset)
         (step && !wrap && !count_down) |=> (count_value == $past(count_value) + 1'b1);
   endproperty
   a_step_visible: assert property (p_step_visible)
      else $error("count did not advance");

   property p_count_hold;
      @(posedge core_clk) disable iff (reset)
         (!step && !reset) |=> (count_value == $past(count_value));
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved without a step");

   property p_overflow_set;
      @(posedge core_clk) disable iff (reset)
         wrap |=> overflow_flag;
   endproperty
   a_overflow_set: assert property (p_overflow_set)
      else $error("overflow not flagged");

   property p_overflow_clear;
      @(posedge core_clk) disable iff (reset)
         (overflow_clear && !wrap) |=> !overflow_flag;
   endproperty
   a_overflow_clear: assert property (p_overflow_clear)
      else $error("overflow not cleared");

   // The pin itself, one machine cycle back, must have been high; this does not trust the
   // sample register that the step logic uses.
   property p_counter_edge;
      @(posedge core_clk) disable iff (reset)
         (run && counter_mode && step)
            |-> (machine_tick && !count_input
                 && $past(count_input, timer_pkg::OSC_PER_MACHINE));
   endproperty
   a_counter_edge: assert property (p_counter_edge)
      else $error("counted without a fall");
endmodule // count_unit

/* File: event_source.sv */
/*
 * Behavioural event source on the three counter input pins.
 * Assumes the machine tick of the counter block; pins idle high.
 */
`timescale 1ns/1ps
module event_source (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       machine_tick,
   input  wire logic [2:0] toggle_en,
   output logic      [2:0] pins = 3'h7
);
   // Moving only at a tick holds every level a full machine cycle, the fastest legal source.
   always @(posedge core_clk) begin
      if (reset) begin
         pins <= 3'h7;
      end else if (machine_tick) begin
         pins <= pins ^ toggle_en;
      end
   end
endmodule // event_source

/* File: tb_top.sv */
/*
 * Self-checking bench for the triple timer/event counter.
 * Assumes the event_source model drives the three pins.
 */
`timescale 1ns/1ps
module tb_top;
   logic                core_clk = 1'b0;
   logic                reset = 1'b1;
   logic [2:0]          run = 3'h0, cmode = 3'h0, tog = 3'h0, clr = 3'h0;
   logic [2:0]          pins, prev_s, flag;
   logic                down = 1'b0, stb = 1'b0, tick, t2out, t_was;
   timer_pkg::t2_mode_t mode = timer_pkg::T2_PLAIN;
   logic [15:0]         rel = 16'h0000, c0, c1, c2, capv;
   logic [15:0]         exp_c [3];
   int                  n_errors = 0, samples_checked = 0, cyc = 0;

   always #10 core_clk = ~core_clk;

   event_source src (.core_clk(core_clk), .reset(reset), .machine_tick(tick),
      .toggle_en(tog), .pins(pins));
   triple_timer_event_counter dut (.core_clk(core_clk), .reset(reset), .run(run),
      .counter_mode(cmode), .timer0_count_input(pins[0]), .timer1_count_input(pins[1]),
      .timer2_count_input(pins[2]), .timer2_mode(mode), .timer2_count_down(down),
      .timer2_reload_value(rel), .timer2_capture_strobe(stb), .overflow_clear(clr),
      .timer0_count(c0), .timer1_count(c1), .timer2_count(c2), .timer2_capture(capv),
      .overflow_flag(flag), .timer2_toggle_out(t2out), .machine_tick(tick));

   // Reference counts, valid while timer 2 is in plain mode.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         stop_test();
      end
      if (reset) begin
         exp_c <= '{default: 16'h0000};
         prev_s <= 3'h0;
      end else if (tick === 1'b1) begin
         for (int i = 0; i < 3; i++) begin
            if (run[i] && (!cmode[i] || (prev_s[i] && !pins[i]))) begin
               exp_c[i] <= exp_c[i] + 16'h0001;
            end
         end
         prev_s <= pins;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_all();
      chk(c0, exp_c[0]);
      chk(c1, exp_c[1]);
      chk(c2, exp_c[2]);
   endtask

   // Ends at a tick edge; with do_chk the counts are compared just before that edge.
   task automatic step(input int n, input bit do_chk);
      repeat (n) begin
         do @(negedge core_clk); while (tick !== 1'b1);
         if (do_chk) chk_all();
         @(posedge core_clk);
      end
   endtask

   task automatic look();
      repeat (2) @(negedge core_clk);
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
   endtask

   task automatic t_free();
      int gap;
      do_reset();
      @(negedge core_clk);
      chk_all();
      @(posedge core_clk);
      run <= 3'h7;
      step(20, 1);
      gap = 0;
      do begin
         @(negedge core_clk);
         gap++;
      end while (tick !== 1'b1 && gap < 40);
      chk(16'(gap), 16'(timer_pkg::OSC_PER_MACHINE));
      @(posedge core_clk);
      run <= 3'h2;
      step(10, 1);
      chk(16'(flag), 16'h0000);
   endtask

   task automatic t_events();
      do_reset();
      @(posedge core_clk);
      cmode <= 3'h7;
      run <= 3'h7;
      tog <= 3'h7;
      step(30, 1);
      tog <= 3'h5;
      step(10, 1);
   endtask

   // Timer 2 counts machine cycles here, so the pins are held still.
   task automatic t_wrap();
      do_reset();
      @(posedge core_clk);
      cmode <= 3'h0;
      tog <= 3'h0;
      run <= 3'h4;
      mode <= timer_pkg::T2_RELOAD;
      down <= 1'b1;
      rel <= 16'h0003;
      step(1, 0);
      look();
      chk(c2, 16'h0003);
      chk(flag[2], 1'b1);
      chk(t2out, 1'b0);
      @(posedge core_clk);
      clr <= 3'h4;
      @(posedge core_clk);
      clr <= 3'h0;
      step(3, 0);
      look();
      chk(flag[2], 1'b0);
      chk(c2, 16'h0000);
      step(1, 0);
      look();
      chk(flag[2], 1'b1);
      @(posedge core_clk);
      mode <= timer_pkg::T2_CAPTURE;
      step(2, 0);
      look();
      @(posedge core_clk);
      stb <= 1'b1;
      @(posedge core_clk);
      stb <= 1'b0;
      look();
      chk(capv, 16'h0005);
      @(posedge core_clk);
      mode <= timer_pkg::T2_RELOAD;
      rel <= 16'hFFFD;
      step(6, 0);
      look();
      chk(c2, 16'hFFFD);
      @(posedge core_clk);
      mode <= timer_pkg::T2_OUTPUT;
      down <= 1'b0;
      look();
      t_was = t2out;
      step(2, 0);
      look();
      chk(t2out, t_was);
      step(1, 0);
      look();
      chk(c2, 16'hFFFD);
      chk(t2out, !t_was);
   endtask

   task automatic stop_test();
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      t_free();
      t_events();
      t_wrap();
      stop_test();
   end
endmodule // tb_top

/* File: timer_pkg.sv */
/*
 * Shared constants for the triple timer/event counter: widths, timing and the Timer 2 modes.
 * Assumes a single 50 MHz core clock that stands for the oscillator.
 */
package timer_pkg;
   localparam int          COUNT_WIDTH        = 16;
   localparam int          OSC_PER_MACHINE    = 12;
   localparam int          MACHINE_CNT_WIDTH  = 4;
   localparam int          EDGE_MACHINE_CYCLES = 2;
   localparam logic [15:0] COUNT_RESET        = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES     = 16'hFFFF;
   localparam logic [3:0]  PRESCALE_RESET     = 4'h0;
   localparam logic [3:0]  PRESCALE_LAST      = 4'(OSC_PER_MACHINE - 1);

   typedef enum logic [1:0] {
      T2_PLAIN   = 2'h0,
      T2_CAPTURE = 2'h1,
      T2_RELOAD  = 2'h2,
      T2_OUTPUT  = 2'h3
   } t2_mode_t;
endpackage

/* File: triple_timer_event_counter.sv */
/*
 * Three independent 16-bit timer/event counters; Timer 2 adds capture, reload, up/down
 * and an output toggle. Assumes control levels come from core logic, pins are synchronous.
 */
// Contract
// - Three independent 16-bit units, each a timer or an event counter.
// - Timer operation adds one to the count every machine cycle.
// - Counter operation adds one only on a falling edge of its input pin.
// - Input sampled each machine cycle; high then low sample marks an edge.
// - The new count shows in the cycle after the edge was detected.
// - Edge recognition takes two machine cycles; max rate is oscillator over 24.
// - Units raise periodic interrupt requests each counting period; here each unit only sets a sticky overflow_flag bit on wrap.
// - Timer 2 is 16-bit with plain, capture, reload up/down and output modes.
// - Timer 2 counts events from its own dedicated input pin.
`timescale 1ns/1ps
module triple_timer_event_counter #(
   parameter int WIDTH = timer_pkg::COUNT_WIDTH
) (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic [2:0]         run,
   input  wire logic [2:0]         counter_mode,
   input  wire logic               timer0_count_input,
   input  wire logic               timer1_count_input,
   input  wire logic               timer2_count_input,
   input  wire timer_pkg::t2_mode_t timer2_mode,
   input  wire logic               timer2_count_down,
   input  wire logic [WIDTH-1:0]   timer2_reload_value,
   input  wire logic               timer2_capture_strobe,
   input  wire logic [2:0]         overflow_clear,
   output logic      [WIDTH-1:0]   timer0_count,
   output logic      [WIDTH-1:0]   timer1_count,
   output logic      [WIDTH-1:0]   timer2_count,
   output logic      [WIDTH-1:0]   timer2_capture,
   output logic      [2:0]         overflow_flag,
   output logic                    timer2_toggle_out,
   output logic                    machine_tick
);
   typedef struct packed {
      logic [3:0] prescale;
      logic [3:0] tick_gap;
   } top_state_t;

   top_state_t       s_q;
   top_state_t       s_d;
   logic [2:0]       pins;
   logic [2:0]       toggles;
   logic [WIDTH-1:0] counts [3];
   logic [WIDTH-1:0] captures [3];
   logic             t2_reload;
   logic             t2_capture;
   logic             t2_down;

   // One machine cycle is twelve core clocks; the tick gates all counting.
   always_comb begin
      s_d = s_q;
      if (s_q.prescale == timer_pkg::PRESCALE_LAST) begin
         s_d.prescale = timer_pkg::PRESCALE_RESET;
      end else begin
         s_d.prescale = s_q.prescale + 4'h1;
      end
      // Counted apart from the prescaler so the period and gap checks do not lean on the logic they
      // watch; only those two checks read it, so synthesis drops it.
      s_d.tick_gap = machine_tick ? 4'h0 : s_q.tick_gap + 4'h1;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign machine_tick = (s_q.prescale == timer_pkg::PRESCALE_LAST);

   // Timer 2 takes its events from its own pin.
   assign pins       = {timer2_count_input, timer1_count_input, timer0_count_input};
   assign t2_reload  = (timer2_mode == timer_pkg::T2_RELOAD) ||
                       (timer2_mode == timer_pkg::T2_OUTPUT);
   assign t2_capture = (timer2_mode == timer_pkg::T2_CAPTURE) && timer2_capture_strobe;
   assign t2_down    = (timer2_mode == timer_pkg::T2_RELOAD) && timer2_count_down;

   // The edge detector needs two machine-cycle samples, so the fastest input the
   // units follow is one event per 24 core clocks; slower sources must hold levels.
   for (genvar i = 0; i < 3; i++) begin : g_unit
      count_unit #(
         .WIDTH(WIDTH)
      ) u_unit (
         .core_clk       (core_clk),
         .reset          (reset),
         .machine_tick   (machine_tick),
         .run            (run[i]),
         .counter_mode   (counter_mode[i]),
         .count_input    (pins[i]),
         .count_down     ((i == 2) ? t2_down : 1'b0),
         .reload_enable  ((i == 2) ? t2_reload : 1'b0),
         .reload_value   (timer2_reload_value),
         .capture_strobe ((i == 2) ? t2_capture : 1'b0),
         .overflow_clear (overflow_clear[i]),
         .count_value    (counts[i]),
         .capture_value  (captures[i]),
         .overflow_flag  (overflow_flag[i]),
         .toggle_out     (toggles[i])
      );
   end

   assign timer0_count      = counts[0];
   assign timer1_count      = counts[1];
   assign timer2_count      = counts[2];
   assign timer2_capture    = captures[2];
   assign timer2_toggle_out = (timer2_mode == timer_pkg::T2_OUTPUT) ? toggles[2] : 1'b0;

   property p_tick_period;
      @(posedge core_clk) disable iff (reset)
         machine_tick |-> (s_q.tick_gap == timer_pkg::PRESCALE_LAST);
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("machine tick not every 12 clocks");

   property p_tick_gap;
      @(posedge core_clk) disable iff (reset)
         (s_q.tick_gap == timer_pkg::PRESCALE_LAST) |-> machine_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("machine tick came late");

   property p_timer0_rate;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[0] && !counter_mode[0] && timer0_count != '1)
            |=> (timer0_count == $past(timer0_count) + 1'b1);
   endproperty
   a_timer0_rate: assert property (p_timer0_rate)
      else $error("timer 0 missed a machine cycle");

   property p_timer1_rate;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[1] && !counter_mode[1] && timer1_count != '1)
            |=> (timer1_count == $past(timer1_count) + 1'b1);
   endproperty
   a_timer1_rate: assert property (p_timer1_rate)
      else $error("timer 1 missed a machine cycle");

   property p_timer0_fall;
      @(posedge core_clk) disable iff (reset)
         (run[0] && counter_mode[0] && machine_tick && !timer0_count_input
            && $past(timer0_count_input, timer_pkg::OSC_PER_MACHINE)
            && $past(machine_tick, timer_pkg::OSC_PER_MACHINE)
            && !$past(reset, timer_pkg::OSC_PER_MACHINE) && timer0_count != '1)
            |=> (timer0_count == $past(timer0_count) + 1'b1);
   endproperty
   a_timer0_fall: assert property (p_timer0_fall)
      else $error("timer 0 missed a fall");

   property p_timer1_edge_latency;
      @(posedge core_clk) disable iff (reset)
         (run[1] && counter_mode[1] && timer1_count_input && machine_tick
            && timer1_count != '1 ##12 (!timer1_count_input && machine_tick && run[1]
            && counter_mode[1])) |=> (timer1_count == $past(timer1_count) + 1'b1);
   endproperty
   a_timer1_edge_latency: assert property (p_timer1_edge_latency)
      else $error("timer 1 missed a fall");

   property p_timer2_own_pin;
      @(posedge core_clk) disable iff (reset)
         (run[2] && counter_mode[2] && machine_tick && timer2_count_input)
            |=> (timer2_count == $past(timer2_count));
   endproperty
   a_timer2_own_pin: assert property (p_timer2_own_pin)
      else $error("timer 2 counted while its pin was high");

   property p_timer0_stopped;
      @(posedge core_clk) disable iff (reset)
         !run[0] |=> (timer0_count == $past(timer0_count));
   endproperty
   a_timer0_stopped: assert property (p_timer0_stopped)
      else $error("timer 0 moved while stopped");

   property p_timer2_stopped;
      @(posedge core_clk) disable iff (reset)
         !run[2] |=> (timer2_count == $past(timer2_count));
   endproperty
   a_timer2_stopped: assert property (p_timer2_stopped)
      else $error("timer 2 moved while stopped");

   property p_t2_output_only;
      @(posedge core_clk) disable iff (reset)
         (timer2_mode != timer_pkg::T2_OUTPUT) |-> !timer2_toggle_out;
   endproperty
   a_t2_output_only: assert property (p_t2_output_only)
      else $error("toggle outside output mode");

   property p_t2_plain_rate;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[2] && !counter_mode[2] && timer2_mode == timer_pkg::T2_PLAIN
            && timer2_count != '1) |=> (timer2_count == $past(timer2_count) + 1'b1);
   endproperty
   a_t2_plain_rate: assert property (p_t2_plain_rate)
      else $error("timer 2 missed a machine cycle");

   property p_t2_down;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[2] && !counter_mode[2] && timer2_mode == timer_pkg::T2_RELOAD
            && timer2_count_down && timer2_count != '0)
            |=> (timer2_count == $past(timer2_count) - 1'b1);
   endproperty
   a_t2_down: assert property (p_t2_down)
      else $error("timer 2 did not count down");

   property p_t2_reload_down;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[2] && !counter_mode[2] && timer2_mode == timer_pkg::T2_RELOAD
            && timer2_count_down && timer2_count == '0)
            |=> (timer2_count == $past(timer2_reload_value));
   endproperty
   a_t2_reload_down: assert property (p_t2_reload_down)
      else $error("timer 2 did not reload on underflow");

   property p_t2_output_wrap;
      @(posedge core_clk) disable iff (reset)
         (machine_tick && run[2] && !counter_mode[2] && timer2_mode == timer_pkg::T2_OUTPUT
            && timer2_count == '1)
            |=> (timer2_count == $past(timer2_reload_value)) && overflow_flag[2]
               && (timer2_mode != timer_pkg::T2_OUTPUT
                   || timer2_toggle_out != $past(timer2_toggle_out));
   endproperty
   a_t2_output_wrap: assert property (p_t2_output_wrap)
      else $error("timer 2 output wrap wrong");

   property p_t2_capture;
      @(posedge core_clk) disable iff (reset)
         (timer2_mode == timer_pkg::T2_CAPTURE && timer2_capture_strobe)
            |=> (timer2_capture == $past(timer2_count));
   endproperty
   a_t2_capture: assert property (p_t2_capture)
      else $error("timer 2 capture missed the count");

   property p_t2_capture_hold;
      @(posedge core_clk) disable iff (reset)
         !(timer2_mode == timer_pkg::T2_CAPTURE && timer2_capture_strobe)
            |=> (timer2_capture == $past(timer2_capture));
   endproperty
   a_t2_capture_hold: assert property (p_t2_capture_hold)
      else $error("timer 2 capture changed without a strobe");

   property p_t2_flag_sticky;
      @(posedge core_clk) disable iff (reset)
         (overflow_flag[2] && !overflow_clear[2]) |=> overflow_flag[2];
   endproperty
   a_t2_flag_sticky: assert property (p_t2_flag_sticky)
      else $error("timer 2 overflow flag dropped");
endmodule // triple_timer_event_counter
